/* mwr_pkg.sv */
package mwr_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned MWR_DATA_W  = 16;
  localparam int unsigned MWR_ADDR_W  = 3;
  localparam int unsigned MWR_N_AXES  = 4;
  localparam int unsigned MWR_GP_W    = 8;
  localparam int unsigned MWR_PARAM_W = 32;

  // ---------------------------------------------------------------
  // Write addresses on the three low address lines
  // ---------------------------------------------------------------
  localparam logic [MWR_ADDR_W-1:0] MWR_ADDR_COMMAND   = 3'h0;
  localparam logic [MWR_ADDR_W-1:0] MWR_ADDR_INT_MODE  = 3'h1;
  localparam logic [MWR_ADDR_W-1:0] MWR_ADDR_SIG_MODE  = 3'h2;
  localparam logic [MWR_ADDR_W-1:0] MWR_ADDR_PROF_MODE = 3'h3;
  localparam logic [MWR_ADDR_W-1:0] MWR_ADDR_GP_XY     = 3'h4;
  localparam logic [MWR_ADDR_W-1:0] MWR_ADDR_GP_ZU     = 3'h5;
  localparam logic [MWR_ADDR_W-1:0] MWR_ADDR_PARAM_LO  = 3'h6;
  localparam logic [MWR_ADDR_W-1:0] MWR_ADDR_PARAM_HI  = 3'h7;

  // ---------------------------------------------------------------
  // Command word fields
  // ---------------------------------------------------------------
  localparam int unsigned MWR_CMD_CODE_LSB = 0;
  localparam int unsigned MWR_CMD_CODE_W   = 8;
  localparam int unsigned MWR_CMD_AXIS_LSB = 8;

  // Axis index order inside every axis-banked vector
  localparam int unsigned MWR_AXIS_X = 0;
  localparam int unsigned MWR_AXIS_Y = 1;
  localparam int unsigned MWR_AXIS_Z = 2;
  localparam int unsigned MWR_AXIS_U = 3;

  // Output register halves: low byte first axis, high byte second
  localparam int unsigned MWR_GP_LO_LSB = 0;
  localparam int unsigned MWR_GP_HI_LSB = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [MWR_DATA_W-1:0] MWR_MODE_RESET  = 16'h0000;
  localparam logic [MWR_DATA_W-1:0] MWR_WORD_RESET  = 16'h0000;
  localparam logic [MWR_GP_W-1:0]   MWR_GP_RESET    = 8'h00;
  localparam logic [3:0]            MWR_AXIS_RESET  = 4'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic {MWR_IDLE, MWR_ARMED} mwr_phase_t;

  typedef struct packed {
    logic                  cs_n;
    logic                  wr_n;
    logic [MWR_ADDR_W-1:0] addr;
    logic [MWR_DATA_W-1:0] data;
  } mwr_host_bus_t;

  typedef struct packed {
    logic [MWR_DATA_W-1:0] interrupt_mode;
    logic [MWR_DATA_W-1:0] signal_mode;
    logic [MWR_DATA_W-1:0] profile_mode;
  } mwr_axis_modes_t;

  typedef struct packed {
    logic interrupt_mode;
    logic signal_mode;
    logic profile_mode;
  } mwr_bank_strobe_t;

  // ---------------------------------------------------------------
  // Decoding shared by the strobe logic
  // ---------------------------------------------------------------
  function automatic mwr_bank_strobe_t mwr_bank_decode(
    input logic [MWR_ADDR_W-1:0] addr
  );
    mwr_bank_strobe_t s;
    s.interrupt_mode = (addr == MWR_ADDR_INT_MODE);
    s.signal_mode    = (addr == MWR_ADDR_SIG_MODE);
    s.profile_mode   = (addr == MWR_ADDR_PROF_MODE);
    return s;
  endfunction

endpackage

/* mwr_sync.sv */
`timescale 1ns/100ps
module mwr_sync
  import mwr_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_value,
  output logic      [WIDTH-1:0] sync_out
);

  // ---------------------------------------------------------------
  // Two-stage synchroniser
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } mwr_sync_state_t;

  localparam mwr_sync_state_t SYNC_RESET = '{default: '1};

  mwr_sync_state_t state_reg;
  mwr_sync_state_t state_next;

  // Stage one feeds stage two only; nothing else may look at it
  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = async_in;
    state_next.stage2 = state_reg.stage1;
  end

  // Idle level of the host strobes is high, so reset to all ones
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= SYNC_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Unused: reset value is fixed to the idle level above
  logic unused_reset_value;
  assign unused_reset_value = ^reset_value;

  assign sync_out = state_reg.stage2;

endmodule

/* mwr_axis_bank.sv */
`timescale 1ns/100ps
module mwr_axis_bank
  import mwr_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire mwr_bank_strobe_t      write_strobe,
  input  wire logic [MWR_DATA_W-1:0] write_data,
  output mwr_axis_modes_t            modes
);

  // ---------------------------------------------------------------
  // One axis copy of the three mode registers
  // ---------------------------------------------------------------
  mwr_axis_modes_t state_reg;
  mwr_axis_modes_t state_next;

  always_comb begin
    state_next = state_reg;
    if (write_strobe.interrupt_mode) begin
      state_next.interrupt_mode = write_data;
    end
    if (write_strobe.signal_mode) begin
      state_next.signal_mode = write_data;
    end
    if (write_strobe.profile_mode) begin
      state_next.profile_mode = write_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '{MWR_MODE_RESET, MWR_MODE_RESET, MWR_MODE_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign modes = state_reg;

endmodule

/* mwr_write_regs.sv */
//
// Function
// - Every host-writable location is sixteen bits wide on the 16-bit bus.
// - Address 000 is the command location carrying axis selection and command code.
// - Each axis owns its own three mode registers, all reached at one shared address each.
// - A mode register write goes to the axis or axes named by the last command written.
// - Address 001 is the per-axis interrupt enable mode register.
// - Address 010 is the per-axis signal mode register for stop inputs and servo signals.
// - The signal mode register also selects limit and software-limit modes.
// - Address 011 is the per-axis profile register for deceleration and acceleration shape.
// - The profile register also selects the drive pulse output mode and pins.
// - The profile register also selects the encoder input mode and pins.
// - Address 100 drives the general-purpose output pins of the first two axes.
// - Address 101 drives the general-purpose output pins of the last two axes.
// - Address 110 captures bits 15 to 0 of the 32-bit data parameter.
// - Address 111 captures bits 31 to 16 of the 32-bit data parameter.
// - Reset clears every mode register of every axis and both output registers.
//
`timescale 1ns/100ps
module mwr_write_regs
  import mwr_pkg::*;
#(
  parameter int unsigned N_AXES = MWR_N_AXES
) (
  input  wire logic                                    ref_clk,
  input  wire logic                                    reset_n,
  input  wire logic                                    host_cs_n,
  input  wire logic                                    host_wr_n,
  input  wire logic [MWR_ADDR_W-1:0]                   host_addr,
  input  wire logic [MWR_DATA_W-1:0]                   host_data,
  output logic                                         command_valid,
  output logic [MWR_CMD_CODE_W-1:0]                    command_code,
  output logic [N_AXES-1:0]                            command_axes,
  output logic [MWR_PARAM_W-1:0]                       command_param,
  output logic [MWR_PARAM_W-1:0]                       param_value,
  output logic [N_AXES-1:0][MWR_DATA_W-1:0]            interrupt_mode_bank,
  output logic [N_AXES-1:0][MWR_DATA_W-1:0]            signal_mode_bank,
  output logic [N_AXES-1:0][MWR_DATA_W-1:0]            profile_mode_bank,
  output logic [MWR_GP_W-1:0]                          x_axis_gp_pins,
  output logic [MWR_GP_W-1:0]                          y_axis_gp_pins,
  output logic [MWR_GP_W-1:0]                          z_axis_gp_pins,
  output logic [MWR_GP_W-1:0]                          u_axis_gp_pins
);

  // ---------------------------------------------------------------
  // Block state
  // ---------------------------------------------------------------
  typedef struct packed {
    mwr_phase_t                   phase;
    logic [MWR_ADDR_W-1:0]        hold_addr;
    logic [MWR_DATA_W-1:0]        hold_data;
    logic [MWR_DATA_W-1:0]        command_word;
    logic [N_AXES-1:0]            axis_sel;
    logic                         command_valid;
    logic [MWR_PARAM_W-1:0]       command_param;
    logic [MWR_DATA_W-1:0]        param_low_half;
    logic [MWR_DATA_W-1:0]        param_high_half;
    logic [MWR_DATA_W-1:0]        gp_output_axes_xy;
    logic [MWR_DATA_W-1:0]        gp_output_axes_zu;
    logic [N_AXES-1:0]            bank_axes;
    mwr_bank_strobe_t             bank_strobe;
    logic [MWR_DATA_W-1:0]        bank_data;
  } mwr_regs_state_t;

  localparam mwr_regs_state_t REGS_RESET = '{
    phase:             MWR_IDLE,
    hold_addr:         MWR_ADDR_COMMAND,
    hold_data:         MWR_WORD_RESET,
    command_word:      MWR_WORD_RESET,
    axis_sel:          '0,
    command_valid:     1'b0,
    command_param:     '0,
    param_low_half:    MWR_WORD_RESET,
    param_high_half:   MWR_WORD_RESET,
    gp_output_axes_xy: MWR_WORD_RESET,
    gp_output_axes_zu: MWR_WORD_RESET,
    bank_axes:         '0,
    bank_strobe:       '0,
    bank_data:         MWR_WORD_RESET
  };

  mwr_regs_state_t state_reg;
  mwr_regs_state_t state_next;

  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  mwr_host_bus_t pins_raw;
  mwr_host_bus_t pins;

  assign pins_raw = '{host_cs_n, host_wr_n, host_addr, host_data};

  // Address and data travel with the strobes, so a skewed sample
  // is only taken while the strobe is already seen low
  mwr_sync #(
    .WIDTH ($bits(mwr_host_bus_t))
  ) u_pin_sync (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .async_in    (pins_raw),
    .reset_value ('1),
    .sync_out    (pins)
  );

  // ---------------------------------------------------------------
  // Write capture and register update
  // ---------------------------------------------------------------
  logic              strobe_low;
  logic [N_AXES-1:0] new_axes;

  assign strobe_low = !pins.cs_n && !pins.wr_n;

  always_comb begin
    state_next               = state_reg;
    state_next.command_valid = 1'b0;
    state_next.bank_strobe   = '0;
    new_axes                 = state_reg.hold_data[MWR_CMD_AXIS_LSB +: N_AXES];
    case (state_reg.phase)
      MWR_IDLE: begin
        if (strobe_low) begin
          state_next.phase     = MWR_ARMED;
          state_next.hold_addr = pins.addr;
          state_next.hold_data = pins.data;
        end
      end
      MWR_ARMED: begin
        if (strobe_low) begin
          // Last sample before the strobe rises is the one kept
          state_next.hold_addr = pins.addr;
          state_next.hold_data = pins.data;
        end else begin
          state_next.phase = MWR_IDLE;
          case (state_reg.hold_addr)
            MWR_ADDR_COMMAND: begin
              state_next.command_word  = state_reg.hold_data;
              state_next.axis_sel      = new_axes;
              state_next.command_valid = 1'b1;
              state_next.command_param = {state_reg.param_high_half,
                                          state_reg.param_low_half};
            end
            MWR_ADDR_GP_XY: begin
              state_next.gp_output_axes_xy = state_reg.hold_data;
            end
            MWR_ADDR_GP_ZU: begin
              state_next.gp_output_axes_zu = state_reg.hold_data;
            end
            MWR_ADDR_PARAM_LO: begin
              state_next.param_low_half = state_reg.hold_data;
            end
            MWR_ADDR_PARAM_HI: begin
              state_next.param_high_half = state_reg.hold_data;
            end
            default: begin
              state_next.bank_strobe = mwr_bank_decode(state_reg.hold_addr);
              state_next.bank_axes   = state_reg.axis_sel;
              state_next.bank_data   = state_reg.hold_data;
            end
          endcase
        end
      end
      default: begin
        state_next.phase = MWR_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= REGS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Axis-banked mode registers
  // ---------------------------------------------------------------
  mwr_axis_modes_t [N_AXES-1:0] axis_modes;

  genvar g;
  generate
    for (g = 0; g < N_AXES; g++) begin : g_axis
      mwr_bank_strobe_t axis_strobe;

      assign axis_strobe = state_reg.bank_axes[g] ? state_reg.bank_strobe : '0;

      mwr_axis_bank u_bank (
        .ref_clk      (ref_clk),
        .reset_n      (reset_n),
        .write_strobe (axis_strobe),
        .write_data   (state_reg.bank_data),
        .modes        (axis_modes[g])
      );

      assign interrupt_mode_bank[g] = axis_modes[g].interrupt_mode;
      assign signal_mode_bank[g]    = axis_modes[g].signal_mode;
      assign profile_mode_bank[g]   = axis_modes[g].profile_mode;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  assign command_valid = state_reg.command_valid;
  assign command_code  = state_reg.command_word[MWR_CMD_CODE_LSB +: MWR_CMD_CODE_W];
  assign command_axes  = state_reg.axis_sel;
  assign command_param = state_reg.command_param;
  assign param_value   = {state_reg.param_high_half, state_reg.param_low_half};

  assign x_axis_gp_pins = state_reg.gp_output_axes_xy[MWR_GP_LO_LSB +: MWR_GP_W];
  assign y_axis_gp_pins = state_reg.gp_output_axes_xy[MWR_GP_HI_LSB +: MWR_GP_W];
  assign z_axis_gp_pins = state_reg.gp_output_axes_zu[MWR_GP_LO_LSB +: MWR_GP_W];
  assign u_axis_gp_pins = state_reg.gp_output_axes_zu[MWR_GP_HI_LSB +: MWR_GP_W];

endmodule

/* mwr_write_regs_assertions.sv */
`timescale 1ns/100ps
module mwr_write_regs_assertions
  import mwr_pkg::*;
#(
  parameter int unsigned N_AXES = MWR_N_AXES
) (
  input wire logic                             ref_clk,
  input wire logic                             reset_n,
  input wire logic                             host_cs_n,
  input wire logic                             host_wr_n,
  input wire logic [MWR_ADDR_W-1:0]            host_addr,
  input wire logic [MWR_DATA_W-1:0]            host_data,
  input wire logic                             command_valid,
  input wire logic [MWR_CMD_CODE_W-1:0]        command_code,
  input wire logic [N_AXES-1:0]                command_axes,
  input wire logic [MWR_PARAM_W-1:0]           command_param,
  input wire logic [MWR_PARAM_W-1:0]           param_value,
  input wire logic [N_AXES-1:0][MWR_DATA_W-1:0] interrupt_mode_bank,
  input wire logic [N_AXES-1:0][MWR_DATA_W-1:0] signal_mode_bank,
  input wire logic [N_AXES-1:0][MWR_DATA_W-1:0] profile_mode_bank,
  input wire logic [MWR_GP_W-1:0]              x_axis_gp_pins,
  input wire logic [MWR_GP_W-1:0]              y_axis_gp_pins,
  input wire logic [MWR_GP_W-1:0]              z_axis_gp_pins,
  input wire logic [MWR_GP_W-1:0]              u_axis_gp_pins
);
  logic [MWR_ADDR_W-1:0] last_addr;
  logic [MWR_DATA_W-1:0] last_data;

  // -------------------------------------------------------------
  // Last word seen on the pins while strobed
  // -------------------------------------------------------------
  // Raw pins are fine: the host holds them two cycles past release, as long as the sync delay
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      last_addr <= 3'h0;
      last_data <= 16'h0000;
    end else if (!host_cs_n && !host_wr_n) begin
      last_addr <= host_addr;
      last_data <= host_data;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  a_valid_pulse: assert property (command_valid |=> !command_valid)
    else $error("command pulse longer than one cycle");
  a_cmd_fields: assert property (command_valid |-> last_addr == MWR_ADDR_COMMAND
      && command_code == last_data[7:0] && command_axes == last_data[11:8])
    else $error("command fields do not match written word");
  a_cmd_latency: assert property ($rose(host_wr_n) && $past(!host_cs_n)
      && host_addr == MWR_ADDR_COMMAND |-> ##[1:4] command_valid)
    else $error("command write not signalled in time");
  a_gp_xy_load: assert property ($changed({y_axis_gp_pins, x_axis_gp_pins})
      |-> last_addr == MWR_ADDR_GP_XY && {y_axis_gp_pins, x_axis_gp_pins} == last_data)
    else $error("first output register changed without its write");
  a_gp_zu_load: assert property ($changed({u_axis_gp_pins, z_axis_gp_pins})
      |-> last_addr == MWR_ADDR_GP_ZU && {u_axis_gp_pins, z_axis_gp_pins} == last_data)
    else $error("second output register changed without its write");
  a_param_low: assert property ($changed(param_value[15:0])
      |-> last_addr == MWR_ADDR_PARAM_LO && param_value[15:0] == last_data)
    else $error("low parameter half changed without its write");
  a_param_high: assert property ($changed(param_value[31:16])
      |-> last_addr == MWR_ADDR_PARAM_HI && param_value[31:16] == last_data)
    else $error("high parameter half changed without its write");
  a_param_snap: assert property (command_valid |-> command_param == param_value)
    else $error("command parameter snapshot differs from stored halves");

  for (genvar a = 0; a < N_AXES; a++) begin : g_axis
    a_int_steer: assert property ($changed(interrupt_mode_bank[a])
        |-> command_axes[a] && last_addr == MWR_ADDR_INT_MODE
        && interrupt_mode_bank[a] == last_data)
      else $error("interrupt mode copy written wrongly");
    a_sig_steer: assert property ($changed(signal_mode_bank[a])
        |-> command_axes[a] && last_addr == MWR_ADDR_SIG_MODE
        && signal_mode_bank[a] == last_data)
      else $error("signal mode copy written wrongly");
    a_prof_steer: assert property ($changed(profile_mode_bank[a])
        |-> command_axes[a] && last_addr == MWR_ADDR_PROF_MODE
        && profile_mode_bank[a] == last_data)
      else $error("profile mode copy written wrongly");
  end

  c_cmd_all_axes: cover property (command_valid && command_axes == 4'hF);
  c_sig_write: cover property ($changed(signal_mode_bank));
  c_gp_zu: cover property ($changed(u_axis_gp_pins));
endmodule

/* mwr_host_model.sv */
`timescale 1ns/100ps
module mwr_host_model
  import mwr_pkg::*;
(
  input wire logic              ref_clk,
  output logic                  host_cs_n,
  output logic                  host_wr_n,
  output logic [MWR_ADDR_W-1:0] host_addr,
  output logic [MWR_DATA_W-1:0] host_data
);
  initial begin
    host_cs_n = 1'b1;
    host_wr_n = 1'b1;
    host_addr = 3'h0;
    host_data = 16'hFFFF;
  end

  // Pins move on the falling edge; extra hold models a slow host
  task automatic write_word(input logic [MWR_ADDR_W-1:0] a, input logic [MWR_DATA_W-1:0] d,
                            input int hold);
    @(negedge ref_clk);
    host_addr = a;
    host_data = d;
    repeat (2) @(negedge ref_clk);
    host_cs_n = 1'b0;
    host_wr_n = 1'b0;
    repeat (3 + hold) @(negedge ref_clk);
    host_cs_n = 1'b1;
    host_wr_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    // Released data floats to the pull-up; address shows junk
    host_data = 16'hFFFF;
    host_addr = ~a;
    repeat (3) @(negedge ref_clk);
  endtask
endmodule

/* mwr_write_regs_bench.sv */
`timescale 1ns/100ps
module mwr_write_regs_bench
  import mwr_pkg::*;
;
  localparam int NO_OPERATION_CODE = 'h00; // Arbitrary code, bank steering ignores it
  logic ref_clk, reset_n, cs_n, wr_n, cmd_valid;
  logic [2:0] addr;
  logic [15:0] data;
  logic [7:0] code, gx, gy, gz, gu;
  logic [3:0] axes;
  logic [31:0] cparam, pval;
  logic [3:0][15:0] b_int, b_sig, b_prof;
  int m_bank[3][4], m_gp[2], m_lo, m_hi, m_code, m_axes, m_cparam;
  int fail_count, check_count, pulses, exp_pulses, seed, i, m, a;

  mwr_write_regs #(.N_AXES(4)) DUT (.ref_clk(ref_clk), .reset_n(reset_n), .host_cs_n(cs_n),
    .host_wr_n(wr_n), .host_addr(addr), .host_data(data), .command_valid(cmd_valid),
    .command_code(code), .command_axes(axes), .command_param(cparam), .param_value(pval),
    .interrupt_mode_bank(b_int), .signal_mode_bank(b_sig), .profile_mode_bank(b_prof),
    .x_axis_gp_pins(gx), .y_axis_gp_pins(gy), .z_axis_gp_pins(gz), .u_axis_gp_pins(gu));
  mwr_host_model host (.ref_clk(ref_clk), .host_cs_n(cs_n), .host_wr_n(wr_n),
    .host_addr(addr), .host_data(data));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (cmd_valid === 1'b1) pulses++;

  // -------------------------------------------------------------
  // Reference model and checks
  // -------------------------------------------------------------
  task automatic model_reset();
    m_bank = '{default: 0};
    m_gp = '{0, 0};
    {m_lo, m_hi, m_code, m_axes, m_cparam} = '0;
  endtask

  task automatic wr(input int wa, input int wd);
    host.write_word(3'(wa), 16'(wd), $random(seed) & 3);
    wd = wd & 'hFFFF;
    case (wa)
      0: begin
        m_code = wd & 'hFF;
        m_axes = (wd >> 8) & 'hF;
        m_cparam = (m_hi << 16) | m_lo;
        exp_pulses++;
      end
      1, 2, 3: for (int k = 0; k < 4; k++) if (m_axes[k]) m_bank[wa-1][k] = wd;
      4: m_gp[0] = wd;
      5: m_gp[1] = wd;
      6: m_lo = wd;
      default: m_hi = wd;
    endcase
  endtask

  task automatic check(input logic [31:0] got, input int exp, input string what);
    check_count++;
    if (got !== 32'(exp)) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, 32'(exp));
    end
  endtask

  task automatic check_all();
    for (int k = 0; k < 4; k++) begin
      check({16'h0000, b_int[k]}, m_bank[0][k], "interrupt mode");
      check({16'h0000, b_sig[k]}, m_bank[1][k], "signal mode");
      check({16'h0000, b_prof[k]}, m_bank[2][k], "profile mode");
    end
    check({16'h0000, gy, gx}, m_gp[0], "gp xy");
    check({16'h0000, gu, gz}, m_gp[1], "gp zu");
    check(pval, (m_hi << 16) | m_lo, "param");
    check(cparam, m_cparam, "command param");
    check({20'h00000, axes, code}, (m_axes << 8) | m_code, "command");
    check(32'(pulses), exp_pulses, "command pulses");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // -------------------------------------------------------------
  // Sequence
  // -------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    final_report();
  end

  initial begin
    seed = 32'hF3F8;
    reset_n = 1'b0;
    model_reset();
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) reset_n = 1'b1;
    check_all();
    // Every axis mask, none and all included, picked by a no-op command
    for (m = 0; m < 16; m++) begin
      wr(0, (m << 8) | NO_OPERATION_CODE);
      for (a = 1; a < 4; a++) wr(a, $random(seed));
      check_all();
    end
    // Halves loaded before the consuming command
    wr(6, $random(seed));
    wr(7, $random(seed));
    wr(0, 'h0F2A);
    check_all();
    for (i = 0; i < 40; i++) begin
      wr($random(seed) & 7, $random(seed));
      check_all();
    end
    @(negedge ref_clk) reset_n = 1'b0;
    model_reset();
    @(negedge ref_clk);
    check_all();
    @(negedge ref_clk) reset_n = 1'b1;
    wr(0, 'h0500);
    wr(2, 'hA5C3);
    check_all();
    final_report();
  end
endmodule

bind mwr_write_regs mwr_write_regs_assertions #(.N_AXES(N_AXES)) u_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .host_cs_n(host_cs_n), .host_wr_n(host_wr_n),
  .host_addr(host_addr), .host_data(host_data), .command_valid(command_valid),
  .command_code(command_code), .command_axes(command_axes), .command_param(command_param),
  .param_value(param_value), .interrupt_mode_bank(interrupt_mode_bank),
  .signal_mode_bank(signal_mode_bank), .profile_mode_bank(profile_mode_bank),
  .x_axis_gp_pins(x_axis_gp_pins), .y_axis_gp_pins(y_axis_gp_pins),
  .z_axis_gp_pins(z_axis_gp_pins), .u_axis_gp_pins(u_axis_gp_pins));
